//--- core/i2cm_pkg.sv
// constants and types for the two-wire register-port master
package i2cm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ  = 100_000_000;
    localparam int unsigned STD_HZ  = 64_000;
    localparam int unsigned FAST_HZ = 400_000;
    // a quarter of a serial clock period; round up so the bus never runs fast
    localparam logic [8:0] QTR_STD  = 9'((CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ));
    localparam logic [8:0] QTR_FAST = 9'((CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));

    // ------------------------------------------------------------
    // address and framing
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FIXED = 4'ha;
    localparam logic       DIR_WRITE  = 1'b0;
    localparam logic       DIR_READ   = 1'b1;
    localparam logic [3:0] ACK_SLOT   = 4'h8;
    localparam logic [1:0] Q_ZERO     = 2'h0;
    localparam logic [8:0] CNT_ZERO   = 9'h000;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_REREAD} i2cm_op_t;
    typedef enum logic [2:0] {S_IDLE, S_START, S_RSTART, S_BIT, S_STOP} i2cm_state_t;
    typedef enum logic [2:0] {PH_ADDR_W, PH_PTR, PH_DATA, PH_ADDR_R, PH_RDATA} i2cm_phase_t;

    typedef struct packed {
        i2cm_state_t st;
        i2cm_phase_t ph;
        i2cm_op_t    op;
        logic [8:0]  cnt;
        logic [1:0]  qtr;
        logic [3:0]  bitn;
        logic [7:0]  shreg;
        logic        fast;
        logic [2:0]  asel;
        logic [7:0]  ptr;
        logic [7:0]  wdat;
        logic        ackbit;
        logic        scl;
        logic        sda_out;
        logic        sda_oe;
        logic        rdy;
        logic        done;
        logic        nack;
        logic [7:0]  rd_data;
    } i2cm_regs_t;

    localparam i2cm_regs_t REGS_RST = '{
        st: S_IDLE, ph: PH_ADDR_W, op: OP_WRITE, cnt: CNT_ZERO, qtr: Q_ZERO,
        bitn: 4'h0, shreg: BYTE_ZERO, fast: 1'b0, asel: 3'h0, ptr: BYTE_ZERO,
        wdat: BYTE_ZERO, ackbit: 1'b1, scl: 1'b1, sda_out: 1'b0, sda_oe: 1'b0,
        rdy: 1'b1, done: 1'b0, nack: 1'b0, rd_data: BYTE_ZERO};

endpackage : i2cm_pkg

//--- core/i2cm_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module i2cm_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } i2cm_sync_t;

    i2cm_sync_t sync_reg;
    i2cm_sync_t sync_next;

    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = din;
        sync_next.s2 = sync_reg.s1;
    end

    // idle bus level is high, so reset to one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_reg <= 2'b11;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg.s2;

endmodule : i2cm_sync

//--- core/i2cm_master.sv
// two-wire bus master that writes and reads one register of the target port
`timescale 1ns/100ps
module i2cm_master
    import i2cm_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire logic            cmd_valid,
    input  wire i2cm_pkg::i2cm_op_t cmd_op,
    input  wire logic            cmd_fast,
    input  wire logic [2:0]      cmd_asel,
    input  wire logic [7:0]      cmd_ptr,
    input  wire logic [7:0]      cmd_wdata,
    output logic                 cmd_ready,
    output logic                 done,
    output logic                 nack,
    output logic [7:0]           rd_data,
    output logic                 scl_out,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe
);
    import i2cm_pkg::*;

    // ------------------------------------------------------------
    // state and pin synchroniser
    // ------------------------------------------------------------
    i2cm_regs_t r_reg;
    i2cm_regs_t r_next;
    logic       sda_s;
    logic       tick;
    logic [8:0] qlim;
    logic       is_rx;

    i2cm_sync u_sda_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (sda_in),
        .dout (sda_s)
    );

    function automatic logic [7:0] load_byte(
        input i2cm_phase_t ph,
        input logic [2:0]  asel,
        input logic [7:0]  ptr,
        input logic [7:0]  wdat
    );
        logic [7:0] b;
        b = BYTE_ZERO;
        case (ph)
            PH_ADDR_W: b = {ADDR_FIXED, asel, DIR_WRITE};
            PH_ADDR_R: b = {ADDR_FIXED, asel, DIR_READ};
            PH_PTR:    b = ptr;
            PH_DATA:   b = wdat;
            default:   b = BYTE_ZERO;
        endcase
        return b;
    endfunction : load_byte

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        is_rx       = (r_reg.ph == PH_RDATA);
        qlim        = (r_reg.fast ? QTR_FAST : QTR_STD) - 9'h001;
        tick        = (r_reg.cnt == qlim);
        if (r_reg.st != S_IDLE) begin
            r_next.cnt = tick ? CNT_ZERO : r_reg.cnt + 9'h001;
            if (tick) begin
                r_next.qtr = r_reg.qtr + 2'h1;
            end
        end
        case (r_reg.st)
            S_IDLE: begin
                if (cmd_valid) begin
                    r_next.rdy  = 1'b0;
                    r_next.nack = 1'b0;
                    r_next.op   = cmd_op;
                    r_next.fast = cmd_fast;
                    r_next.asel = cmd_asel;
                    r_next.ptr  = cmd_ptr;
                    r_next.wdat = cmd_wdata;
                    r_next.cnt  = CNT_ZERO;
                    r_next.qtr  = Q_ZERO;
                    r_next.st   = S_START;
                    // target still holds the old pointer, so skip it
                    r_next.ph   = (cmd_op == OP_REREAD) ? PH_ADDR_R : PH_ADDR_W;
                end
            end
            S_START: begin
                if (tick) begin
                    case (r_reg.qtr)
                        2'h0: begin
                            r_next.sda_oe = 1'b0;
                            r_next.scl    = 1'b1;
                        end
                        2'h1: r_next.sda_oe = 1'b1;
                        2'h2: r_next.scl = 1'b0;
                        default: begin
                            r_next.st    = S_BIT;
                            r_next.bitn  = 4'h0;
                            r_next.shreg = load_byte(r_reg.ph, r_reg.asel, r_reg.ptr,
                                                     r_reg.wdat);
                        end
                    endcase
                end
            end
            S_RSTART: begin
                if (tick) begin
                    case (r_reg.qtr)
                        2'h0: r_next.sda_oe = 1'b0;
                        2'h1: r_next.scl = 1'b1;
                        2'h2: r_next.sda_oe = 1'b1;
                        default: begin
                            r_next.scl   = 1'b0;
                            r_next.st    = S_BIT;
                            r_next.bitn  = 4'h0;
                            r_next.shreg = load_byte(PH_ADDR_R, r_reg.asel, r_reg.ptr,
                                                     r_reg.wdat);
                        end
                    endcase
                end
            end
            S_BIT: begin
                if (tick) begin
                    case (r_reg.qtr)
                        2'h0: begin
                            r_next.scl = 1'b0;
                            if (r_reg.bitn < ACK_SLOT) begin
                                // open drain: drive only the zeros
                                r_next.sda_oe = is_rx ? 1'b0 : !r_reg.shreg[7];
                            end else begin
                                r_next.sda_oe = is_rx;
                            end
                        end
                        2'h1: r_next.scl = 1'b1;
                        2'h2: begin
                            if (r_reg.bitn < ACK_SLOT) begin
                                if (is_rx) begin
                                    r_next.shreg = {r_reg.shreg[6:0], sda_s};
                                end
                            end else begin
                                r_next.ackbit = sda_s;
                            end
                        end
                        default: begin
                            r_next.scl = 1'b0;
                            if (r_reg.bitn < ACK_SLOT) begin
                                r_next.bitn = r_reg.bitn + 4'h1;
                                if (!is_rx) begin
                                    r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                                end
                            end else if (is_rx) begin
                                r_next.rd_data = r_reg.shreg;
                                r_next.st      = S_STOP;
                            end else if (r_reg.ackbit) begin
                                // no answer: a foreign or absent target
                                r_next.nack = 1'b1;
                                r_next.st   = S_STOP;
                            end else begin
                                r_next.bitn = 4'h0;
                                case (r_reg.ph)
                                    PH_ADDR_W: begin
                                        r_next.ph    = PH_PTR;
                                        r_next.shreg = r_reg.ptr;
                                    end
                                    PH_PTR: begin
                                        if (r_reg.op == OP_WRITE) begin
                                            r_next.ph    = PH_DATA;
                                            r_next.shreg = r_reg.wdat;
                                        end else begin
                                            r_next.ph = PH_ADDR_R;
                                            r_next.st = S_RSTART;
                                        end
                                    end
                                    PH_ADDR_R: begin
                                        r_next.ph    = PH_RDATA;
                                        r_next.shreg = BYTE_ZERO;
                                    end
                                    default: r_next.st = S_STOP;
                                endcase
                            end
                        end
                    endcase
                end
            end
            S_STOP: begin
                if (tick) begin
                    case (r_reg.qtr)
                        2'h0: r_next.sda_oe = 1'b1;
                        2'h1: r_next.scl = 1'b1;
                        2'h2: r_next.sda_oe = 1'b0;
                        default: begin
                            r_next.st   = S_IDLE;
                            r_next.rdy  = 1'b1;
                            r_next.done = 1'b1;
                        end
                    endcase
                end
            end
            default: r_next = REGS_RST;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cmd_ready = r_reg.rdy;
    assign done      = r_reg.done;
    assign nack      = r_reg.nack;
    assign rd_data   = r_reg.rd_data;
    assign scl_out   = r_reg.scl;
    assign sda_out   = r_reg.sda_out;
    assign sda_oe    = r_reg.sda_oe;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_addr_fixed;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st == S_BIT && r_reg.bitn == 4'h0 && r_reg.qtr == Q_ZERO
         && (r_reg.ph == PH_ADDR_W || r_reg.ph == PH_ADDR_R))
        |-> r_reg.shreg[7:1] == {ADDR_FIXED, r_reg.asel};
    endproperty
    a_addr_fixed: assert property (p_addr_fixed)
        else $error("address byte has wrong prefix or select bits");

    property p_asel_held;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st != S_IDLE && $past(r_reg.st) != S_IDLE) |-> $stable(r_reg.asel);
    endproperty
    a_asel_held: assert property (p_asel_held)
        else $error("address select changed during a transfer");

    property p_ack_released;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st == S_BIT && r_reg.bitn == ACK_SLOT && r_reg.ph != PH_RDATA
         && r_reg.qtr != Q_ZERO) |-> !r_reg.sda_oe;
    endproperty
    a_ack_released: assert property (p_ack_released)
        else $error("master drove data during target acknowledge");

    property p_qtr_len;
        @(posedge clk) disable iff (!nrst)
        r_reg.cnt < (r_reg.fast ? QTR_FAST : QTR_STD);
    endproperty
    a_qtr_len: assert property (p_qtr_len)
        else $error("quarter period counter overran its limit");

    property p_data_clk_low;
        @(posedge clk) disable iff (!nrst)
        ($changed(r_reg.sda_oe) && r_reg.st == S_BIT && $past(r_reg.st) == S_BIT)
        |-> !r_reg.scl && $past(r_reg.scl) == 1'b0;
    endproperty
    a_data_clk_low: assert property (p_data_clk_low)
        else $error("data changed while clock high inside a byte");

    property p_start_stop;
        @(posedge clk) disable iff (!nrst)
        ((r_reg.st == S_START && r_reg.qtr == 2'h2) |-> r_reg.sda_oe && r_reg.scl)
        and ((r_reg.st == S_STOP && r_reg.qtr == 2'h3) |-> !r_reg.sda_oe && r_reg.scl);
    endproperty
    a_start_stop: assert property (p_start_stop)
        else $error("start or stop framing wrong");

    property p_dir_bit;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st == S_BIT && r_reg.bitn == 4'h0 && r_reg.qtr == Q_ZERO)
        |-> (r_reg.ph == PH_ADDR_W) ? r_reg.shreg[0] == DIR_WRITE
          : (r_reg.ph == PH_ADDR_R) ? r_reg.shreg[0] == DIR_READ : 1'b1;
    endproperty
    a_dir_bit: assert property (p_dir_bit)
        else $error("direction bit wrong");

    property p_ptr_data;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st == S_BIT && r_reg.bitn == 4'h0 && r_reg.qtr == Q_ZERO && r_reg.ph == PH_PTR)
        |-> r_reg.shreg == r_reg.ptr;
    endproperty
    a_ptr_data: assert property (p_ptr_data)
        else $error("pointer byte not loaded");

    property p_write_end;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st == S_BIT && r_reg.ph == PH_DATA && r_reg.bitn == ACK_SLOT
         && r_reg.qtr == 2'h3 && tick) |=> r_reg.st == S_STOP;
    endproperty
    a_write_end: assert property (p_write_end)
        else $error("write did not close with a stop");

    property p_master_ack;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st == S_BIT && r_reg.bitn == ACK_SLOT && r_reg.ph == PH_RDATA
         && r_reg.qtr != Q_ZERO) |-> r_reg.sda_oe;
    endproperty
    a_master_ack: assert property (p_master_ack)
        else $error("master did not acknowledge read data");

    property p_rstart;
        @(posedge clk) disable iff (!nrst)
        (r_reg.st == S_RSTART && r_reg.qtr == 2'h2) |-> !r_reg.sda_oe && r_reg.scl;
    endproperty
    a_rstart: assert property (p_rstart)
        else $error("repeated start did not raise data first");

    c_write: cover property (@(posedge clk) disable iff (!nrst)
        r_reg.done && r_reg.op == OP_WRITE && !r_reg.nack);
    c_read: cover property (@(posedge clk) disable iff (!nrst)
        r_reg.done && r_reg.op == OP_READ && !r_reg.nack);
    c_reread: cover property (@(posedge clk) disable iff (!nrst)
        r_reg.done && r_reg.op == OP_REREAD);
    c_nack: cover property (@(posedge clk) disable iff (!nrst)
        r_reg.done && r_reg.nack);

endmodule : i2cm_master

//--- testbench/i2cm_target_model.sv
// behavioural two-wire register target that stands on the far side of the master
`timescale 1ns/100ps
module i2cm_target_model
    import i2cm_pkg::*;
(
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [2:0] asel,
    output logic            sda_pull
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] mem [256];
    logic [7:0] ptr_reg;
    logic [7:0] sh_reg;
    logic [7:0] rsh_reg;
    logic       sel_reg;
    logic       rd_reg;
    int         bitc;
    int         byten;

    initial begin
        sda_pull = 1'b0;
        ptr_reg  = 8'h00;
        sh_reg   = 8'h00;
        rsh_reg  = 8'h00;
        sel_reg  = 1'b0;
        rd_reg   = 1'b0;
        bitc     = 0;
        byten    = -1;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // framing: only edges of data while clock is high count
    // ------------------------------------------------------------
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bitc     = 0;
            byten    = 0;
            sel_reg  = 1'b0;
            sda_pull <= 1'b0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            byten    = -1;
            sda_pull <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bit sampling on rising clock, driving on falling clock
    // ------------------------------------------------------------
    always @(posedge scl) begin
        if (byten >= 0 && bitc < 9) begin
            if (bitc < 8) begin
                sh_reg = {sh_reg[6:0], sda};
            end
            bitc = bitc + 1;
        end
    end

    // the pointer survives every frame; only an address-plus-pointer write moves it
    always @(negedge scl) begin
        if (byten >= 0) begin
            if (bitc == 8) begin
                if (byten == 0) begin
                    sel_reg = (sh_reg[7:1] === {ADDR_FIXED, asel});
                    rd_reg  = sh_reg[0];
                    rsh_reg = mem[ptr_reg];
                end else if (sel_reg && !rd_reg && byten == 1) begin
                    ptr_reg = sh_reg;
                end else if (sel_reg && !rd_reg && byten == 2) begin
                    mem[ptr_reg] = sh_reg;
                end
                sda_pull <= sel_reg && !(rd_reg && byten > 0);
            end else if (bitc == 9) begin
                bitc  = 0;
                byten = byten + 1;
                sda_pull <= sel_reg && rd_reg && byten == 1 && !rsh_reg[7];
            end else if (sel_reg && rd_reg && byten == 1) begin
                sda_pull <= !rsh_reg[7 - bitc];
            end
        end
    end
endmodule : i2cm_target_model

//--- testbench/tb_i2c_register_target_port.sv
// self-checking bench for the two-wire register-port master
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((exp) !== (got)) begin \
            num_errors++; \
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module tb_i2c_register_target_port;
    import i2cm_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       clk;
    logic       nrst;
    logic       cmd_valid;
    i2cm_op_t   cmd_op;
    logic       cmd_fast;
    logic [2:0] cmd_asel;
    logic [7:0] cmd_ptr;
    logic [7:0] cmd_wdata;
    logic       cmd_ready;
    logic       done;
    logic       nack;
    logic [7:0] rd_data;
    logic       scl_out;
    logic       sda_in;
    logic       sda_out;
    logic       sda_oe;
    logic       tgt_pull;
    logic [2:0] tgt_asel;
    logic       sda_wire;
    int         num_errors = 0;
    int         tests_run  = 0;
    int         starts     = 0;
    int         stops      = 0;
    int         q_fast     = int'(QTR_FAST);
    int         q_std      = int'(QTR_STD);

    // open-drain data line with pull-up
    assign sda_wire = (sda_oe === 1'b1 || tgt_pull === 1'b1) ? 1'b0 : 1'b1;
    assign sda_in   = sda_wire;

    i2cm_master u_i2cm_master (
        .clk       (clk),
        .nrst      (nrst),
        .cmd_valid (cmd_valid),
        .cmd_op    (cmd_op),
        .cmd_fast  (cmd_fast),
        .cmd_asel  (cmd_asel),
        .cmd_ptr   (cmd_ptr),
        .cmd_wdata (cmd_wdata),
        .cmd_ready (cmd_ready),
        .done      (done),
        .nack      (nack),
        .rd_data   (rd_data),
        .scl_out   (scl_out),
        .sda_in    (sda_in),
        .sda_out   (sda_out),
        .sda_oe    (sda_oe)
    );

    i2cm_target_model u_i2cm_target_model (
        .scl      (scl_out),
        .sda      (sda_wire),
        .asel     (tgt_asel),
        .sda_pull (tgt_pull)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // count start and stop conditions on the wire
    always @(negedge sda_wire) if (scl_out === 1'b1) starts++;
    always @(posedge sda_wire) if (scl_out === 1'b1) stops++;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    function automatic logic near(input int got, input int exp);
        return (got >= exp - 3) && (got <= exp + 3);
    endfunction : near

    // cmd_ready idles high, so the request is taken at the edge after it is raised
    task automatic run_cmd(input i2cm_op_t op, input logic fast, input logic [2:0] asel,
                           input logic [7:0] ptr, input logic [7:0] wdat, output int cyc);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_fast  = fast;
        cmd_asel  = asel;
        cmd_ptr   = ptr;
        cmd_wdata = wdat;
        starts    = 0;
        stops     = 0;
        @(negedge clk);
        cmd_valid = 1'b0;
        cyc       = 0;
        `CHECK("busy", 1'b0, cmd_ready)
        while (done !== 1'b1 && cyc < 50000) begin
            @(negedge clk);
            cyc++;
        end
        // a transfer that never ends counts here as a mismatch
        `CHECK("done seen", 1'b1, done)
        @(negedge clk);
        `CHECK("done pulse", 1'b0, done)
        `CHECK("ready back", 1'b1, cmd_ready)
    endtask : run_cmd

    task automatic print_verdict;
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        `CHECK("ready", 1'b1, cmd_ready)
        `CHECK("scl idle", 1'b1, scl_out)
        `CHECK("sda oe idle", 1'b0, sda_oe)
        `CHECK("sda out tied", 1'b0, sda_out)
        $display("test_reset done");
    endtask : test_reset

    task automatic test_write_fast;
        int cyc;
        run_cmd(OP_WRITE, 1'b1, 3'h3, 8'h5c, 8'ha7, cyc);
        `CHECK("write nack", 1'b0, nack)
        `CHECK("pointer", 8'h5c, u_i2cm_target_model.ptr_reg)
        `CHECK("stored", 8'ha7, u_i2cm_target_model.mem[8'h5c])
        `CHECK("starts", 1, starts)
        `CHECK("stops", 1, stops)
        `CHECK("write time", 1'b1, near(cyc, 116 * q_fast))
        `CHECK("scl after", 1'b1, scl_out)
        $display("test_write_fast done");
    endtask : test_write_fast

    task automatic test_read_fast;
        int cyc;
        run_cmd(OP_WRITE, 1'b1, 3'h3, 8'h3c, 8'h5e, cyc);
        run_cmd(OP_READ, 1'b1, 3'h3, 8'h5c, 8'h00, cyc);
        `CHECK("read nack", 1'b0, nack)
        `CHECK("read data", 8'ha7, rd_data)
        `CHECK("read starts", 2, starts)
        `CHECK("read stops", 1, stops)
        `CHECK("read time", 1'b1, near(cyc, 156 * q_fast))
        $display("test_read_fast done");
    endtask : test_read_fast

    task automatic test_reread_std;
        int cyc;
        run_cmd(OP_REREAD, 1'b0, 3'h3, 8'h3c, 8'h00, cyc);
        `CHECK("reread data", 8'ha7, rd_data)
        `CHECK("pointer kept", 8'h5c, u_i2cm_target_model.ptr_reg)
        `CHECK("reread starts", 1, starts)
        `CHECK("reread time", 1'b1, near(cyc, 80 * q_std))
        $display("test_reread_std done");
    endtask : test_reread_std

    task automatic test_address_select;
        int cyc;
        run_cmd(OP_WRITE, 1'b1, 3'h5, 8'h5c, 8'h11, cyc);
        `CHECK("foreign nack", 1'b1, nack)
        `CHECK("foreign kept", 8'ha7, u_i2cm_target_model.mem[8'h5c])
        `CHECK("foreign stops", 1, stops)
        tgt_asel = 3'h5;
        run_cmd(OP_WRITE, 1'b1, 3'h5, 8'h5c, 8'h11, cyc);
        `CHECK("select nack", 1'b0, nack)
        `CHECK("select stored", 8'h11, u_i2cm_target_model.mem[8'h5c])
        run_cmd(OP_REREAD, 1'b1, 3'h5, 8'h00, 8'h00, cyc);
        `CHECK("select read", 8'h11, rd_data)
        $display("test_address_select done");
    endtask : test_address_select

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        nrst      = 1'b0;
        cmd_valid = 1'b0;
        cmd_op    = OP_WRITE;
        cmd_fast  = 1'b0;
        cmd_asel  = 3'h0;
        cmd_ptr   = 8'h00;
        cmd_wdata = 8'h00;
        tgt_asel  = 3'h3;
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        test_reset();
        test_write_fast();
        test_read_fast();
        test_reread_std();
        test_address_select();
        print_verdict();
    end

    // whole run is near 71k cycles; stop a hang at 90k
    initial begin
        #900000;
        num_errors++;
        print_verdict();
    end
endmodule : tb_i2c_register_target_port
